// [rtl/pcicm_pkg.sv]
// constants, register map and carrier types of the pci config mirror bank
package pcicm_pkg;

    // register byte addresses on the local bus
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_CLASS = 8'h04;
    localparam logic [7:0] OFS_LINE  = 8'h08;
    localparam logic [7:0] OFS_ISTS  = 8'h0C;
    localparam logic [7:0] OFS_IMSK  = 8'h10;

    // command/status mirror bit positions
    localparam int unsigned BIT_IO_SPACE_ENABLE   = 0;
    localparam int unsigned BIT_MEMORY_SPACE_ENABLE  = 1;
    localparam int unsigned BIT_BUS_MASTER_ENABLE  = 2;
    localparam int unsigned BIT_SPC     = 3;
    localparam int unsigned BIT_MWI     = 4;
    localparam int unsigned BIT_PAL     = 5;
    localparam int unsigned BIT_PERR_RS = 6;
    localparam int unsigned BIT_STEP    = 7;
    localparam int unsigned BIT_SYSTEM_ERROR_PIN_ENABLE = 8;
    localparam int unsigned BIT_QTURN   = 9;
    localparam int unsigned BIT_DET_PE  = 31;

    // class/revision fields and reset values
    localparam int unsigned CLS_BASE_LSB = 24;
    localparam int unsigned CLS_SUB_LSB  = 16;
    localparam int unsigned CLS_PROG_LSB = 8;
    localparam logic [7:0] CLS_BASE_RST = 8'h11;
    localparam logic [7:0] CLS_SUB_RST  = 8'h80;
    localparam logic [7:0] CLS_PROG_RST = 8'h00;

    // line/latency/header mirror fields and values
    localparam int unsigned LINE_LAT_LSB = 8;
    localparam logic [7:0] LINE_LAT_RST = 8'h00;
    localparam logic [7:0] LINE_LEN_RST = 8'h00;
    localparam logic [7:0] LINE_LEN_16B = 8'h04;
    localparam logic [15:0] LINE_FIXED   = 16'h0000;

    // interrupt status/mask bits
    localparam int unsigned IRQ_W    = 2;
    localparam int unsigned IRQ_PERR = 0;
    localparam int unsigned IRQ_SERR = 1;

    typedef struct packed {
        logic system_error_pin_enable;
        logic par_resp;
        logic mwi_en;
        logic spc_en;
        logic bm_en;
        logic mem_en;
    } pcicm_cmd_s;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pcicm_avm_s;

    typedef struct packed {
        pcicm_cmd_s       cmd;
        logic             det_pe;
        logic [31:0]      cls;
        logic [7:0]       lat;
        logic [7:0]       len;
        logic [IRQ_W-1:0] ists;
        logic [IRQ_W-1:0] imsk;
        logic             perr_drv;
        logic             serr_drv;
        logic             ack;
        logic [31:0]      rdata;
    } pcicm_state_s;

endpackage : pcicm_pkg

// [rtl/pcicm_regs.sv]
// pci configuration mirror register bank with avalon-mm slave
// How it works
// - quick turnaround enable reads zero; fast back-to-back never enabled.
// - system error pin driven only when system error pin enable set.
// - no address stepping; address stepping control reads zero.
// - parity response set: detected parity error drives parity error pin.
// - parity response clear: flag still set, pin stays quiet.
// - palette snoop bit reads zero.
// - write and invalidate allowed only while its enable is set.
// - special cycles ignored unless special cycle bit set; resets to zero.
// - master transactions start only while bus master enable set.
// - memory target accesses accepted only while memory space enable set.
// - io accesses never accepted; io space enable reads zero.
// - class fields writable, reset 11h, 80h and zero.
// - low class byte is writable revision field, reset to identity code.
// - self test and header layout fields read-only zero.
// - tenure limit and line length writable, both reset zero.
// - unsupported line length write leaves zero; 4h is kept.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
module pcicm_regs #(
    // arbitrary neutral revision value
    parameter logic [7:0] REV_RST = 8'h5A
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [pcicm_pkg::ADDR_W-1:0] avs_address,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        parity_err_seen,
    input  wire logic                        sys_err_cond,
    input  wire logic                        master_req,
    input  wire logic                        write_invalidate_req,
    input  wire logic                        mem_hit,
    input  wire logic                        io_hit,
    input  wire logic                        special_cycle_seen,
    output logic                             master_start,
    output logic                             write_invalidate_use,
    output logic                             mem_target_accept,
    output logic                             io_target_accept,
    output logic                             special_cycle_accept,
    output logic                             quick_turnaround_enable,
    output logic                             parity_error_pin_o,
    output logic                             parity_error_pin_oe,
    output logic                             system_error_pin_o,
    output logic                             system_error_pin_oe,
    output logic                             detected_parity_error_flag,
    output logic                             irq
);

    // elaboration check: the register map needs five address bits
    if ($bits(avs_address) < 5) begin : g_addr_check
        $error("address too narrow for register map");
    end

    pcicm_pkg::pcicm_state_s st_q;
    pcicm_pkg::pcicm_state_s st_d;
    pcicm_pkg::pcicm_avm_s   req;
    logic                    req_any;
    logic                    wr_go;
    logic [31:0]             wmerge;

    assign req = '{read: avs_read, write: avs_write,
                   address: avs_address, writedata: avs_writedata,
                   byteenable: avs_byteenable};
    assign req_any = req.read | req.write;
    // first cycle of every access waits, second completes
    assign avs_waitrequest = req_any & ~st_q.ack;
    assign wr_go = req.write & st_q.ack;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // command mirror image; fixed bits read as zero
    function automatic logic [31:0] cmd_word(
        input pcicm_pkg::pcicm_state_s s
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pcicm_pkg::BIT_MEMORY_SPACE_ENABLE]  = s.cmd.mem_en;
        w[pcicm_pkg::BIT_BUS_MASTER_ENABLE]  = s.cmd.bm_en;
        w[pcicm_pkg::BIT_SPC]     = s.cmd.spc_en;
        w[pcicm_pkg::BIT_MWI]     = s.cmd.mwi_en;
        w[pcicm_pkg::BIT_PERR_RS] = s.cmd.par_resp;
        w[pcicm_pkg::BIT_SYSTEM_ERROR_PIN_ENABLE] = s.cmd.system_error_pin_enable;
        w[pcicm_pkg::BIT_DET_PE]  = s.det_pe;
        return w;
    endfunction

    function automatic logic [31:0] rd_word(
        input pcicm_pkg::pcicm_state_s s,
        input logic [7:0]              a
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            pcicm_pkg::OFS_CMD: begin
                w = cmd_word(s);
            end
            pcicm_pkg::OFS_CLASS: begin
                w = s.cls;
            end
            pcicm_pkg::OFS_LINE: begin
                w = {pcicm_pkg::LINE_FIXED, s.lat, s.len};
            end
            pcicm_pkg::OFS_ISTS: begin
                w[pcicm_pkg::IRQ_W-1:0] = s.ists;
            end
            pcicm_pkg::OFS_IMSK: begin
                w[pcicm_pkg::IRQ_W-1:0] = s.imsk;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    assign wmerge = be_merge(rd_word(st_q, req.address),
                             req.writedata, req.byteenable);

    always_comb begin
        st_d = st_q;
        st_d.ack = req_any & ~st_q.ack;
        if (req_any & ~st_q.ack) begin
            st_d.rdata = rd_word(st_q, req.address);
        end
        if (wr_go) begin
            case (req.address)
                pcicm_pkg::OFS_CMD: begin
                    if (req.byteenable[0]) begin
                        st_d.cmd.mem_en   = wmerge[pcicm_pkg::BIT_MEMORY_SPACE_ENABLE];
                        st_d.cmd.bm_en    = wmerge[pcicm_pkg::BIT_BUS_MASTER_ENABLE];
                        st_d.cmd.spc_en   = wmerge[pcicm_pkg::BIT_SPC];
                        st_d.cmd.mwi_en   = wmerge[pcicm_pkg::BIT_MWI];
                        st_d.cmd.par_resp = wmerge[pcicm_pkg::BIT_PERR_RS];
                    end
                    if (req.byteenable[1]) begin
                        st_d.cmd.system_error_pin_enable = wmerge[pcicm_pkg::BIT_SYSTEM_ERROR_PIN_ENABLE];
                    end
                    if (req.byteenable[3] &&
                        req.writedata[pcicm_pkg::BIT_DET_PE]) begin
                        st_d.det_pe = 1'b0;
                    end
                end
                pcicm_pkg::OFS_CLASS: begin
                    st_d.cls = wmerge;
                end
                pcicm_pkg::OFS_LINE: begin
                    st_d.lat = wmerge[pcicm_pkg::LINE_LAT_LSB +: 8];
                    if (req.byteenable[0]) begin
                        // only disabled or 16-byte lines survive
                        st_d.len = (req.writedata[7:0] ==
                                    pcicm_pkg::LINE_LEN_16B) ?
                                   pcicm_pkg::LINE_LEN_16B :
                                   pcicm_pkg::LINE_LEN_RST;
                    end
                end
                pcicm_pkg::OFS_ISTS: begin
                    if (req.byteenable[0]) begin
                        st_d.ists = st_q.ists &
                            ~req.writedata[pcicm_pkg::IRQ_W-1:0];
                    end
                end
                pcicm_pkg::OFS_IMSK: begin
                    if (req.byteenable[0]) begin
                        st_d.imsk = req.writedata[pcicm_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                    st_d.cls = st_q.cls;
                end
            endcase
        end
        // events after software clears so a set in the same cycle wins
        st_d.perr_drv = parity_err_seen & st_q.cmd.par_resp;
        st_d.serr_drv = sys_err_cond & st_q.cmd.system_error_pin_enable;
        if (parity_err_seen) begin
            st_d.det_pe = 1'b1;
            st_d.ists[pcicm_pkg::IRQ_PERR] = 1'b1;
        end
        if (st_d.serr_drv & ~st_q.serr_drv) begin
            st_d.ists[pcicm_pkg::IRQ_SERR] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{cmd: '0, det_pe: 1'b0,
                      cls: {pcicm_pkg::CLS_BASE_RST,
                            pcicm_pkg::CLS_SUB_RST,
                            pcicm_pkg::CLS_PROG_RST, REV_RST},
                      lat: pcicm_pkg::LINE_LAT_RST,
                      len: pcicm_pkg::LINE_LEN_RST,
                      ists: '0, imsk: '0, perr_drv: 1'b0,
                      serr_drv: 1'b0, ack: 1'b0,
                      rdata: 32'h0000_0000};
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata = st_q.rdata;
    // open-drain pins pull low while enabled
    assign parity_error_pin_o  = 1'b0;
    assign parity_error_pin_oe = st_q.perr_drv;
    assign system_error_pin_o  = 1'b0;
    assign system_error_pin_oe = st_q.serr_drv;
    assign master_start = master_req & st_q.cmd.bm_en;
    assign write_invalidate_use = write_invalidate_req &
                                  st_q.cmd.mwi_en & st_q.cmd.bm_en;
    assign mem_target_accept = mem_hit & st_q.cmd.mem_en;
    assign io_target_accept = io_hit & 1'b0;
    assign special_cycle_accept = special_cycle_seen &
                                  st_q.cmd.spc_en;
    assign quick_turnaround_enable = 1'b0;
    assign detected_parity_error_flag = st_q.det_pe;
    assign irq = |(st_q.ists & st_q.imsk);

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic rd_cmd;
    logic rd_line;
    assign rd_cmd  = req.read & st_q.ack & (req.address == pcicm_pkg::OFS_CMD);
    assign rd_line = req.read & st_q.ack &
                     (req.address == pcicm_pkg::OFS_LINE);

    a_quick_turn_zero: assert property (
        rd_cmd |-> !avs_readdata[pcicm_pkg::BIT_QTURN] &&
                   !quick_turnaround_enable)
        else $error("quick turnaround bit not zero");

    a_serr_pin_gate: assert property (
        system_error_pin_oe |-> $past(sys_err_cond && st_q.cmd.system_error_pin_enable))
        else $error("system error pin driven while disabled");
    a_serr_pin_quiet: assert property (
        !st_q.cmd.system_error_pin_enable |=> !system_error_pin_oe)
        else $error("system error pin driven after disable");

    a_step_ctl_zero: assert property (
        rd_cmd |-> !avs_readdata[pcicm_pkg::BIT_STEP])
        else $error("address stepping bit not zero");

    a_perr_pin_drive: assert property (
        parity_err_seen && st_q.cmd.par_resp |=> parity_error_pin_oe)
        else $error("parity error not driven on pin");

    a_perr_quiet_flag: assert property (
        parity_err_seen && !st_q.cmd.par_resp |=>
            !parity_error_pin_oe && detected_parity_error_flag)
        else $error("parity error handling wrong when disabled");
    a_perr_pin_quiet: assert property (
        !st_q.cmd.par_resp |=> !parity_error_pin_oe)
        else $error("parity error pin driven while disabled");
    a_det_pe_set: assert property (
        parity_err_seen |=> detected_parity_error_flag)
        else $error("detected parity flag not set");

    a_palette_zero: assert property (
        rd_cmd |-> !avs_readdata[pcicm_pkg::BIT_PAL])
        else $error("palette snoop bit not zero");

    a_mwi_gate: assert property (
        write_invalidate_use |-> st_q.cmd.mwi_en)
        else $error("write invalidate used while disabled");
    a_mwi_master: assert property (
        write_invalidate_use |-> st_q.cmd.bm_en)
        else $error("write invalidate used while not master");
    a_mwi_pass: assert property (
        write_invalidate_req && st_q.cmd.mwi_en && st_q.cmd.bm_en |->
            write_invalidate_use)
        else $error("write invalidate blocked while enabled");

    a_special_gate: assert property (
        special_cycle_accept |-> st_q.cmd.spc_en)
        else $error("special cycle accepted while disabled");
    a_special_pass: assert property (
        special_cycle_seen && st_q.cmd.spc_en |-> special_cycle_accept)
        else $error("special cycle refused while enabled");
    a_spc_write: assert property (
        wr_go && req.address == pcicm_pkg::OFS_CMD && req.byteenable[0]
        |=> st_q.cmd.spc_en == $past(req.writedata[pcicm_pkg::BIT_SPC]))
        else $error("special cycle bit write lost");

    a_master_gate: assert property (
        master_start |-> st_q.cmd.bm_en)
        else $error("master started while disabled");
    a_master_pass: assert property (
        master_req && st_q.cmd.bm_en |-> master_start)
        else $error("master start blocked while enabled");

    a_mem_gate: assert property (
        mem_target_accept |-> st_q.cmd.mem_en)
        else $error("memory access accepted while disabled");
    a_mem_pass: assert property (
        mem_hit && st_q.cmd.mem_en |-> mem_target_accept)
        else $error("memory access refused while enabled");
    a_enable_write: assert property (
        wr_go && req.address == pcicm_pkg::OFS_CMD && req.byteenable[0]
        |=> st_q.cmd.bm_en == $past(req.writedata[pcicm_pkg::BIT_BUS_MASTER_ENABLE]) &&
            st_q.cmd.mem_en == $past(req.writedata[pcicm_pkg::BIT_MEMORY_SPACE_ENABLE]))
        else $error("enable bit write lost");

    a_io_never: assert property (
        !io_target_accept && !(rd_cmd && avs_readdata[pcicm_pkg::BIT_IO_SPACE_ENABLE]))
        else $error("io access accepted or io bit set");
    a_cmd_fixed: assert property (
        rd_cmd |-> (avs_readdata & 32'h7FFF_FEA1) == 32'h0000_0000)
        else $error("fixed command bits not zero");

    a_class_write: assert property (
        wr_go && req.address == pcicm_pkg::OFS_CLASS &&
        req.byteenable == 4'hF |=> st_q.cls == $past(req.writedata))
        else $error("class mirror write lost");

    a_header_fixed: assert property (
        rd_line |-> avs_readdata[31:16] == pcicm_pkg::LINE_FIXED)
        else $error("self test or header field not zero");

    a_line_legal: assert property (
        st_q.len == pcicm_pkg::LINE_LEN_RST ||
        st_q.len == pcicm_pkg::LINE_LEN_16B)
        else $error("unsupported line length stored");
    a_len_keep: assert property (
        wr_go && req.address == pcicm_pkg::OFS_LINE && req.byteenable[0] &&
        req.writedata[7:0] == pcicm_pkg::LINE_LEN_16B
        |=> st_q.len == pcicm_pkg::LINE_LEN_16B)
        else $error("supported line length not kept");
    a_len_drop: assert property (
        wr_go && req.address == pcicm_pkg::OFS_LINE && req.byteenable[0] &&
        req.writedata[7:0] != pcicm_pkg::LINE_LEN_16B
        |=> st_q.len == pcicm_pkg::LINE_LEN_RST)
        else $error("unsupported line length not cleared");

    a_lat_write: assert property (
        wr_go && req.address == pcicm_pkg::OFS_LINE && req.byteenable[1]
        |=> st_q.lat == $past(req.writedata[15:8]))
        else $error("tenure limit write lost");

    a_bus_answer: assert property (
        req_any && !st_q.ack |=> !avs_waitrequest)
        else $error("bus answer late");
    a_ack_one_cycle: assert property (
        st_q.ack |=> !st_q.ack)
        else $error("bus answer held too long");

    c_perr_flagged: cover property (
        parity_err_seen && st_q.cmd.par_resp ##1 parity_error_pin_oe);
    c_serr_irq: cover property (
        system_error_pin_oe && st_q.imsk[pcicm_pkg::IRQ_SERR] ##1 irq);
    c_line_16b: cover property (
        wr_go && req.address == pcicm_pkg::OFS_LINE ##1
        st_q.len == pcicm_pkg::LINE_LEN_16B);
    c_master_go: cover property (master_start);
    c_io_refused: cover property (io_hit && !io_target_accept);

endmodule // pcicm_regs

// [bench/pcicm_agent_model.sv]
// far side model: core events, bus traffic decode and pulled-up error pins
module pcicm_agent_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       perr_req,
    input  wire logic       serr_req,
    input  wire logic [4:0] traffic,
    input  wire logic       parity_error_pin_o,
    input  wire logic       parity_error_pin_oe,
    input  wire logic       system_error_pin_o,
    input  wire logic       system_error_pin_oe,
    output logic            parity_err_seen,
    output logic            sys_err_cond,
    output logic            master_req,
    output logic            write_invalidate_req,
    output logic            mem_hit,
    output logic            io_hit,
    output logic            special_cycle_seen,
    output logic            perr_wire,
    output logic            serr_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic perr_req_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_req_q      <= 1'b0;
            parity_err_seen <= 1'b0;
            sys_err_cond    <= 1'b0;
            {master_req, write_invalidate_req, mem_hit, io_hit,
             special_cycle_seen} <= 5'h00;
        end else begin
            perr_req_q      <= perr_req;
            // one detection pulse per request
            parity_err_seen <= perr_req & ~perr_req_q;
            sys_err_cond    <= serr_req;
            {master_req, write_invalidate_req, mem_hit, io_hit,
             special_cycle_seen} <= traffic;
        end
    end

    // both pins are pulled up; undriven reads high
    assign perr_wire = parity_error_pin_oe ?
                       parity_error_pin_o : 1'b1;
    assign serr_wire = system_error_pin_oe ?
                       system_error_pin_o : 1'b1;
endmodule // pcicm_agent_model

// [bench/tb_pcicm_regs.sv]
// register, gating and error pin tests of the config mirror bank
module tb_pcicm_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV_EXP = 8'h5A; // arbitrary neutral value
    logic        ref_clk = 1'b0, rst_n = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic [3:0]  avs_byteenable = 4'h0;
    logic        avs_waitrequest, perr_req = 1'b0, serr_req = 1'b0;
    logic [4:0]  traffic = 5'h00;
    logic        parity_err_seen, sys_err_cond, master_req;
    logic        write_invalidate_req, mem_hit, io_hit, special_cycle_seen;
    logic        master_start;
    logic        write_invalidate_use, mem_target_accept, io_target_accept;
    logic        special_cycle_accept, quick_turnaround_enable, irq;
    logic        pe_o, pe_oe, se_o, se_oe, det_flag, perr_wire, serr_wire;
    int          miscompares = 0, samples_checked = 0;
    logic        seen_p, seen_s;

    always #20 ref_clk = ~ref_clk;

    pcicm_regs #(.REV_RST(REV_EXP)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
        .avs_write(avs_write), .avs_address(avs_address),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .parity_err_seen(parity_err_seen), .sys_err_cond(sys_err_cond),
        .master_req(master_req), .write_invalidate_req(write_invalidate_req),
        .mem_hit(mem_hit), .io_hit(io_hit),
        .special_cycle_seen(special_cycle_seen), .master_start(master_start),
        .write_invalidate_use(write_invalidate_use),
        .mem_target_accept(mem_target_accept),
        .io_target_accept(io_target_accept),
        .special_cycle_accept(special_cycle_accept),
        .quick_turnaround_enable(quick_turnaround_enable),
        .parity_error_pin_o(pe_o), .parity_error_pin_oe(pe_oe),
        .system_error_pin_o(se_o), .system_error_pin_oe(se_oe),
        .detected_parity_error_flag(det_flag), .irq(irq));

    pcicm_agent_model agent (
        .ref_clk(ref_clk), .rst_n(rst_n), .perr_req(perr_req),
        .serr_req(serr_req), .traffic(traffic), .parity_error_pin_o(pe_o),
        .parity_error_pin_oe(pe_oe), .system_error_pin_o(se_o),
        .system_error_pin_oe(se_oe), .parity_err_seen(parity_err_seen),
        .sys_err_cond(sys_err_cond), .master_req(master_req),
        .write_invalidate_req(write_invalidate_req), .mem_hit(mem_hit),
        .io_hit(io_hit), .special_cycle_seen(special_cycle_seen),
        .perr_wire(perr_wire), .serr_wire(serr_wire));

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
            n++;
        end
        chk("wait cycles", n, 32'h1);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, 4'hF, q);
        chk(name, q, exp);
    endtask

    // raise core error requests and watch both pins for a few cycles
    task automatic event_watch(output logic sp, output logic ss);
        sp = 1'b0;
        ss = 1'b0;
        perr_req <= 1'b1;
        serr_req <= 1'b1;
        repeat (5) begin
            @(negedge ref_clk);
            if (perr_wire === 1'b0) sp = 1'b1;
            if (serr_wire === 1'b0) ss = 1'b1;
        end
        @(posedge ref_clk);
        perr_req <= 1'b0;
        serr_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd("cmd reset", pcicm_pkg::OFS_CMD, 32'h00000000);
        rd("class reset", pcicm_pkg::OFS_CLASS,
           {24'h118000, REV_EXP});
        rd("line reset", pcicm_pkg::OFS_LINE, 32'h00000000);
        rd("ists reset", pcicm_pkg::OFS_ISTS, 32'h00000000);
        wr(pcicm_pkg::OFS_CMD, 32'hFFFFFFFF, 4'hF);
        rd("cmd fixed bits", pcicm_pkg::OFS_CMD,
           32'h0000015E);
        chk("quick turnaround", quick_turnaround_enable, 1'b0);
        for (int en = 1; en >= 0; en--) begin
            wr(pcicm_pkg::OFS_CMD, en ? 32'h0000015E : 32'h0, 4'hF);
            traffic <= 5'h1F;
            repeat (2) @(negedge ref_clk);
            chk("master start", master_start, en[0]);
            chk("mwi use", write_invalidate_use, en[0]);
            chk("mem accept", mem_target_accept, en[0]);
            chk("io accept", io_target_accept, 1'b0);
            chk("special accept", special_cycle_accept, en[0]);
            @(posedge ref_clk);
            traffic <= 5'h00;
            @(posedge ref_clk);
        end
        for (int k = 0; k < 2; k++) begin
            wr(pcicm_pkg::OFS_CMD, k ? 32'h00000140 : 32'h0, 4'hF);
            wr(pcicm_pkg::OFS_IMSK, k ? 32'h3 : 32'h0, 4'hF);
            event_watch(seen_p, seen_s);
            chk("parity pin", seen_p, k[0]);
            chk("serr pin", seen_s, k[0]);
            chk("det flag", det_flag, 1'b1);
            rd("cmd det", pcicm_pkg::OFS_CMD,
               (k ? 32'h140 : 32'h0) | 32'h80000000);
            rd("ists", pcicm_pkg::OFS_ISTS, {30'h0, k[0], 1'b1});
            rd("imsk", pcicm_pkg::OFS_IMSK, k ? 32'h3 : 32'h0);
            chk("irq", irq, k[0]);
            wr(pcicm_pkg::OFS_ISTS, 32'h00000003, 4'hF);
            wr(pcicm_pkg::OFS_CMD, 32'h80000000, 4'h8);
            repeat (2) @(posedge ref_clk);
            chk("irq clear", irq, 1'b0);
            rd("det clear", pcicm_pkg::OFS_CMD, k ? 32'h140 : 32'h0);
        end
        wr(pcicm_pkg::OFS_CLASS, 32'hA5C33C69, 4'hF);
        rd("class rw", pcicm_pkg::OFS_CLASS, 32'hA5C33C69);
        for (int v = 0; v < 8; v++) begin
            wr(pcicm_pkg::OFS_LINE, {24'hFFFF3C, 8'(v)}, 4'hF);
            rd("line len", pcicm_pkg::OFS_LINE,
               {24'h00003C,
                (v == 4) ? 8'h04 : 8'h00});
        end
        wr(8'h20, 32'hFFFFFFFF, 4'hF);
        rd("unmapped", 8'h20, 32'h00000000);
        rd("class kept", pcicm_pkg::OFS_CLASS, 32'hA5C33C69);
        tally_and_finish();
    end
endmodule // tb_pcicm_regs
